// ### design/brs_device.sv
// regulator sequencer: enable, soft start, power-good, limits, hiccup
`timescale 1ns/1ps
module brs_device
  import brs_pkg::*;
#(
  parameter int PG_CYC     = PG_DELAY_CYC,
  parameter int HICCUP_LEN = HICCUP_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  brs_if.device            bus,
  input  wire logic        i_enable_pin,
  input  wire logic        i_input_low_lockout,
  input  wire logic        i_input_overvolt,
  input  wire logic [31:0] i_feedback_sense,   // microvolts
  input  wire logic        i_peak_current_limit,
  output logic             o_upper_on,
  output logic             o_lower_on,
  output logic             o_light_load,
  output logic             o_output_in_range_flag,
  output logic             o_feedback_undervolt,
  output logic [31:0]      o_ref_uv
);
  //////////////////////////////////////////////////////////////////////
  // registers
  brs_state_t  state_q, state_d;
  logic [6:0]  code_q;
  logic [7:0]  ctrl_q, slew_q;
  logic [31:0] ref_q, ref_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] pg_cnt_q;
  logic [7:0]  blank_q;
  logic        ack_q;
  logic        pg_q;

  //////////////////////////////////////////////////////////////////////
  // decode
  wire logic        wr_code  = bus.wr_valid && bus.wr_addr == CMD_CODE;
  wire logic        wr_ctrl  = bus.wr_valid && bus.wr_addr == CMD_CTRL;
  wire logic        wr_slew  = bus.wr_valid && bus.wr_addr == CMD_SLEW;
  wire logic [31:0] target   = brs_ref_uv(code_q);
  wire logic        reg_en   = ctrl_q[CTRL_EN_BIT];
  wire logic        ov_fault = ctrl_q[CTRL_OV_BIT] && i_input_overvolt;
  wire logic        go       = i_enable_pin && !i_input_low_lockout
                               && reg_en && !ov_fault;
  wire logic [31:0] ref_step = ref_q + {24'h0, slew_q};
  // thresholds as fractions of the reference
  wire logic [35:0] fb_x10   = {4'h0, i_feedback_sense} * 36'd10;
  wire logic [35:0] ref_x8   = {4'h0, ref_q} * 36'd8;
  wire logic [35:0] ref_x9   = {4'h0, ref_q} * 36'd9;
  wire logic [35:0] ref_x11  = {4'h0, ref_q} * 36'd11;
  wire logic        feedback_undervolt    = fb_x10 < ref_x8;
  wire logic        fb_pg_ok = fb_x10 >= ref_x9 &&
                               (!ctrl_q[CTRL_PGB_BIT] || fb_x10 <= ref_x11);
  wire logic        in_run   = state_q == ST_RUN;
  wire logic        switching = state_q == ST_RAMP || in_run;
  wire logic        fb_low   = i_feedback_sense < ref_q;
  wire logic        blanked  = blank_q != 8'h0;

  //////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_d = state_q;
    ref_d   = ref_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_OFF: begin
        ref_d = 32'h0;
        cnt_d = 32'h0;
        if (go) state_d = ST_BIAS;
      end
      ST_BIAS: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(BIAS_CYC - 1)) begin
          state_d = ST_RAMP;
          cnt_d   = 32'h0;
        end
      end
      ST_RAMP: begin
        if (ref_step >= target) begin
          ref_d   = target;
          state_d = ST_RUN;
        end else begin
          ref_d = ref_step;
        end
      end
      ST_RUN: begin
        ref_d = target;
        if (feedback_undervolt) begin
          state_d = ST_HICCUP;
          cnt_d   = 32'h0;
        end
      end
      ST_HICCUP: begin
        cnt_d = cnt_q + 32'h1;
        ref_d = 32'h0;
        if (cnt_q == 32'(HICCUP_LEN - 1)) begin
          state_d = ST_RAMP;
          cnt_d   = 32'h0;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (!go) state_d = ST_OFF;
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer and bus registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_OFF;
      ref_q   <= 32'h0;
      cnt_q   <= 32'h0;
      code_q  <= CODE_RST;
      ctrl_q  <= CTRL_RST;
      slew_q  <= SLEW_RST;
      ack_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ref_q   <= ref_d;
      cnt_q   <= cnt_d;
      ack_q   <= bus.wr_valid;
      if (wr_code) code_q <= bus.wr_data[6:0];
      if (wr_ctrl) ctrl_q <= bus.wr_data;
      if (wr_slew) slew_q <= bus.wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // power-good delay, restarts on any dip
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pg_cnt_q <= 32'h0;
      pg_q     <= 1'b0;
    end else if (!in_run || !fb_pg_ok) begin
      pg_cnt_q <= 32'h0;
      pg_q     <= 1'b0;
    end else if (pg_cnt_q == 32'(PG_CYC - 1)) begin
      pg_q     <= 1'b1;
    end else begin
      pg_cnt_q <= pg_cnt_q + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // switch drive with current-limit blanking
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      blank_q <= 8'h0;
    end else if (i_peak_current_limit) begin
      blank_q <= 8'(BLANK_CYC);
    end else if (blanked) begin
      blank_q <= blank_q - 8'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_upper_on             <= 1'b0;
      o_lower_on             <= 1'b0;
      o_light_load           <= 1'b1;
      o_output_in_range_flag <= 1'b0;
      o_feedback_undervolt   <= 1'b0;
      o_ref_uv               <= 32'h0;
    end else begin
      // registered, the trip also forces upper off at the next edge
      o_upper_on   <= switching && fb_low && !blanked
                      && !i_peak_current_limit;
      o_lower_on   <= switching && !fb_low;
      o_light_load <= (state_q != ST_RUN) ||
                      ctrl_q[CTRL_LL_BIT];
      o_output_in_range_flag <= pg_q;
      o_feedback_undervolt   <= in_run && feedback_undervolt;
      o_ref_uv               <= ref_q;
    end
  end

  assign bus.wr_ack = ack_q;
  assign bus.status = {3'h0, pg_q, state_q == ST_HICCUP, in_run,
                       state_q == ST_RAMP, go};
endmodule : brs_device

// ### design/brs_host.sv
// host bus controller end: turns user writes into bus writes
`timescale 1ns/1ps
module brs_host
  import brs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  brs_if.host             bus,
  input  wire logic       i_req,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_status
);
  logic       valid_q;
  logic [1:0] addr_q;
  logic [7:0] data_q;

  //////////////////////////////////////////////////////////////////////
  // one outstanding write, strobe held one cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      valid_q  <= 1'b0;
      addr_q   <= 2'h0;
      data_q   <= 8'h0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
      o_status <= 8'h0;
    end else begin
      valid_q  <= i_req && !o_busy;
      o_done   <= bus.wr_ack;
      o_status <= bus.status;
      if (i_req && !o_busy) begin
        addr_q <= i_addr;
        data_q <= i_data;
        o_busy <= 1'b1;
      end else if (bus.wr_ack) begin
        o_busy <= 1'b0;
      end
    end
  end

  assign bus.wr_valid = valid_q;
  assign bus.wr_addr  = addr_q;
  assign bus.wr_data  = data_q;
endmodule : brs_host

// ### pkg/brs_if.sv
// interface joining host bus controller and regulator sequencer
`timescale 1ns/1ps
interface brs_if;
  logic       wr_valid;  // one-cycle write strobe
  logic [1:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_ack;    // one-cycle write acknowledge
  logic [7:0] status;    // sequencer status byte
  modport host   (output wr_valid, wr_addr, wr_data, input wr_ack, status);
  modport device (input wr_valid, wr_addr, wr_data, output wr_ack, status);
endinterface : brs_if

// ### pkg/brs_pkg.sv
// constants and types shared by both ends of the regulator sequencer
//
// Overview of operation
// - reference equals offset plus code times step
// - start only with enable high, no lockout
// - ramp reference from zero at programmed slew
// - power-good held low during the ramp
// - power-good rises 45 ms after threshold reached
// - force light-load operation during the ramp
// - current limit kills upper switch at the next edge
// - upper switch stays off 360 ns after trip
// - undervoltage after startup starts hiccup sequence
// - hiccup holds switches off 1.2 ms, restarts
// - undervoltage ignored while startup in progress
// - host enables or disables regulator over bus
// - host selects light-load or continuous conduction
// - host bit gates input overvoltage shutdown
// - host picks power-good on both or under
// - bus accepts writes, code changes while running
// - undervoltage flagged below 80 percent of reference
package brs_pkg;
  localparam int          CLK_MHZ          = 250;
  localparam int          PG_DELAY_MS      = 45;
  localparam int          PG_DELAY_CYC     = PG_DELAY_MS * 1000 * CLK_MHZ;
  localparam int          HICCUP_US_X10    = 12000;  // 1.2 ms in 0.1 us
  localparam int          HICCUP_CYC       = HICCUP_US_X10 * CLK_MHZ / 10;
  localparam int          BLANK_NS         = 360;
  localparam int          BLANK_CYC        = (BLANK_NS * CLK_MHZ) / 1000;
  localparam int          BIAS_CYC         = 16;     // bias settle wait
  // reference in microvolts: offset and step
  localparam logic [31:0] REF_BASE_UV      = 32'h000927c0; // 600000
  localparam logic [31:0] REF_STEP_UV      = 32'h0000125c; // 4700
  localparam int          CODE_W           = 7;
  localparam logic [6:0]  CODE_RST         = 7'h40;
  localparam logic [7:0]  SLEW_RST         = 8'h10;  // uV per cycle
  // command register addresses on the host command port
  localparam logic [1:0]  CMD_CODE         = 2'h0;
  localparam logic [1:0]  CMD_CTRL         = 2'h1;
  localparam logic [1:0]  CMD_SLEW         = 2'h2;
  // control byte fields
  localparam int          CTRL_EN_BIT      = 0;
  localparam int          CTRL_LL_BIT      = 1;
  localparam int          CTRL_OV_BIT      = 2;
  localparam int          CTRL_PGB_BIT     = 3;
  localparam logic [7:0]  CTRL_RST         = 8'h0f;

  typedef enum logic [4:0] {
    ST_OFF    = 5'b00001,
    ST_BIAS   = 5'b00010,
    ST_RAMP   = 5'b00100,
    ST_RUN    = 5'b01000,
    ST_HICCUP = 5'b10000
  } brs_state_t;

  // target reference for a code, in microvolts
  function automatic logic [31:0] brs_ref_uv(input logic [6:0] code);
    brs_ref_uv = REF_BASE_UV + REF_STEP_UV * {25'h0, code};
  endfunction : brs_ref_uv
endpackage : brs_pkg

// ### testbench/brs_checker.sv
// concurrent checks on the joined regulator sequencer ends
`timescale 1ns/1ps
module brs_checker #(
  parameter int PG_CYC  = 20,
  parameter int HIC_LEN = 30
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       wr_valid,
  input  wire logic       wr_ack,
  input  wire logic [7:0] status,
  input  wire logic       i_peak_current_limit,
  input  wire logic       o_upper_on,
  input  wire logic       o_light_load,
  input  wire logic       o_output_in_range_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  int run_q;
  int hic_q;
  // consecutive running cycles, the floor for the power-good delay
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) run_q <= 0;
    else run_q <= status[2] ? run_q + 1 : 0;
  end
  // consecutive hiccup cycles, compared when the restart ramp begins
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) hic_q <= 0;
    else hic_q <= status[3] ? hic_q + 1 : 0;
  end
  ////////////////////////////////////////
  property p_ack; wr_valid |=> wr_ack; endproperty
  a_ack: assert property (p_ack) else $error("write not acked");
  property p_trip; i_peak_current_limit |=> !o_upper_on; endproperty
  a_trip: assert property (p_trip) else $error("trip ignored");
  property p_blank;
    $fell(i_peak_current_limit) |-> !o_upper_on [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("blanking short");
  property p_ramp_pg; status[1] |-> !o_output_in_range_flag; endproperty
  a_ramp_pg: assert property (p_ramp_pg) else $error("pg in ramp");
  property p_ramp_ll; status[1] |-> o_light_load; endproperty
  a_ramp_ll: assert property (p_ramp_ll) else $error("ramp mode");
  property p_hic_len;
    $rose(status[3]) |-> status[3] [*8] ##[1:40] status[1];
  endproperty
  a_hic_len: assert property (p_hic_len) else $error("hiccup len");
  property p_hic_cnt;
    $fell(status[3]) && status[1] |-> hic_q == HIC_LEN;
  endproperty
  a_hic_cnt: assert property (p_hic_cnt) else $error("hiccup count");
  property p_uv_start; status[1] |=> !status[3]; endproperty
  a_uv_start: assert property (p_uv_start) else $error("uv in ramp");
  property p_pg_dly;
    $rose(o_output_in_range_flag) |-> run_q >= PG_CYC - 1;
  endproperty
  a_pg_dly: assert property (p_pg_dly) else $error("pg early");
  c_hic: cover property ($rose(status[3]));
  c_pg: cover property ($rose(o_output_in_range_flag));
  c_trip: cover property ($fell(i_peak_current_limit));
endmodule : brs_checker

// ### testbench/brs_tb_top.sv
// self-checking bench: host end and sequencer joined by the interface
`timescale 1ns/1ps
module brs_tb_top;
  import brs_pkg::*;
  logic        i_clk = 1'b0, i_reset = 1'b1, req = 1'b0;
  logic        en = 1'b0, lock = 1'b1, ovv = 1'b0, lim = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  data = 8'h00, st;
  logic [31:0] fb = 32'h0, ref_uv;
  logic        busy, done, up, lo, ll, pg, uv;
  int          fails = 0, num_checks = 0, cnt = 0;
  brs_if bf();
  brs_host i_brs_host (.i_clk, .i_reset, .bus(bf), .i_req(req),
    .i_addr(addr), .i_data(data), .o_busy(busy), .o_done(done),
    .o_status(st));
  brs_device #(.PG_CYC(20), .HICCUP_LEN(30)) i_brs_device (.i_clk,
    .i_reset, .bus(bf), .i_enable_pin(en), .i_input_low_lockout(lock),
    .i_input_overvolt(ovv), .i_feedback_sense(fb),
    .i_peak_current_limit(lim), .o_upper_on(up), .o_lower_on(lo),
    .o_light_load(ll), .o_output_in_range_flag(pg),
    .o_feedback_undervolt(uv), .o_ref_uv(ref_uv));
  brs_checker #(.PG_CYC(20), .HIC_LEN(30)) i_brs_checker (.i_clk,
    .i_reset, .wr_valid(bf.wr_valid), .wr_ack(bf.wr_ack),
    .status(bf.status), .i_peak_current_limit(lim), .o_upper_on(up),
    .o_light_load(ll), .o_output_in_range_flag(pg));
  ////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cnt <= cnt + 1;
    if (cnt == 40000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // wait n edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  // one user write through the host end, done awaited under a bound
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    int k;
    k = 0;
    addr = a;
    data = d;
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    chk(busy, 1'b1);
    while (done !== 1'b1 && k < 9) begin
      cyc(1);
      k++;
    end
    chk(done, 1'b1);
    chk(busy, 1'b0);
  endtask : wr
  task automatic wst(input int b);
    int k;
    k = 0;
    while (bf.status[b] !== 1'b1 && k < 9000) begin
      cyc(1);
      k++;
    end
    chk(bf.status[b], 1'b1);
  endtask : wst
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////
  // main sequence
  initial begin
    cyc(8);
    chk({ll, up, pg}, 3'b100);
    i_reset = 1'b0;
    wr(CMD_SLEW, 8'hff);
    wr(CMD_CODE, 8'h00);
    wr(2'h3, 8'h7f); // unmapped, must leave the code alone
    wr(CMD_CTRL, 8'h0d);
    en = 1'b1;
    cyc(20);
    chk(bf.status[0], 1'b0);
    lock = 1'b0;
    wst(1);
    chk(ref_uv <= 32'h1fe, 1'b1);
    cyc(20);
    chk({uv, bf.status[3]}, 2'b00);
    wst(2);
    fb = 32'h927c0;
    cyc(3);
    chk(ref_uv, REF_BASE_UV);
    chk(ll, 1'b0);
    cyc(10);
    chk(pg, 1'b0);
    fb = 32'h7a120; // under the good band, above undervoltage
    cyc(3);
    chk(bf.status[3], 1'b0);
    chk(uv, 1'b0);
    fb = 32'h927c0;
    cyc(15);
    chk(pg, 1'b0);
    cyc(10);
    chk(pg, 1'b1);
    chk(st, 8'h15);
    fb = 32'haae60;
    cyc(3);
    chk(pg, 1'b0);
    chk({up, lo}, 2'b01);
    wr(CMD_CTRL, 8'h05);
    cyc(30);
    chk(pg, 1'b1);
    fb = 32'h900b0;
    cyc(3);
    chk({up, lo}, 2'b10);
    lim = 1'b1;
    cyc(1);
    lim = 1'b0;
    cyc(80);
    chk(up, 1'b0);
    cyc(20);
    chk(up, 1'b1);
    wr(CMD_CODE, 8'h7f);
    cyc(1);
    chk(uv, 1'b1);
    cyc(1);
    chk(ref_uv, REF_BASE_UV + REF_STEP_UV * 32'h7f);
    wst(3);
    cyc(2);
    chk({up, lo}, 2'b00);
    wst(1);
    wr(CMD_CODE, 8'h00);
    wst(2);
    wr(CMD_CTRL, 8'h07);
    cyc(2);
    chk(ll, 1'b1);
    ovv = 1'b1;
    cyc(3);
    chk(bf.status[0], 1'b0);
    wr(CMD_CTRL, 8'h03);
    cyc(3);
    chk(bf.status[0], 1'b1);
    wr(CMD_CTRL, 8'h02);
    cyc(3);
    chk({bf.status[0], up, lo}, 3'b000);
    print_verdict();
  end
endmodule : brs_tb_top
